// ### encoderless_speed_monitor.v
// Encoderless speed monitor with channel checks and safety status word.
`timescale 1ns/10ps
`include "esm_defs.vh"
module encoderless_speed_monitor (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire mode_enable,
	input wire keep_speed,
	input wire [3:0] pole_pairs,
	input wire [15:0] scan_time_ms,
	input wire [19:0] pt1_time_us,
	input wire [15:0] pos_diff_limit,
	input wire [15:0] pos_diff_time_ms,
	input wire [15:0] speed_tol,
	input wire [15:0] speed_tol_time_ms,
	input wire [7:0] cur_hyst_pct,
	input wire [15:0] ctrl_hyst_ticks,
	input wire speed_input_assigned,
	input wire bus_started,
	input wire speed_ctrl_bits_set,
	input wire eval_tick,
	input wire signed [15:0] pos_step_a,
	input wire signed [15:0] pos_step_b,
	input wire signed [15:0] cur_speed,
	input wire [15:0] cur_magnitude,
	input wire signed [15:0] phase_cur_sum,
	input wire [15:0] duty_ticks,
	input wire ack_pin,
	input wire torque_off_req_pin,
	input wire brake_req_pin,
	input wire [13:0] func_active,
	input wire limit_breach,
	output reg signed [15:0] speed,
	output reg speed_valid,
	output reg config_error,
	output reg safe_state,
	output reg torque_off_active,
	output reg [31:0] safety_status_word
);
	localparam [15:0] FULL_SCALE = `CUR_FULL_SCALE;
	localparam [15:0] PT1_MIN_US = `PT1_MIN_US;
	reg [1:0] ack_s;
	reg [1:0] sto_s;
	reg [1:0] brk_s;
	reg ack_d;
	wire ack_rise = ack_s[1] & ~ack_d;
	reg signed [31:0] acc_a;
	reg signed [31:0] acc_b;
	reg signed [31:0] acc_a_old;
	reg [15:0] scan_cnt;
	reg bus_d;
	reg bus_window;
	wire scan_done = eval_tick && (scan_cnt + 16'h0001 >= scan_time_ms);
	wire signed [31:0] pos_delta = acc_a - acc_a_old;
	wire signed [31:0] ch_diff = acc_a - acc_b;
	wire [31:0] ch_diff_abs = ch_diff[31] ? -ch_diff : ch_diff;
	wire pos_exceeded = mode_enable && (ch_diff_abs > {16'h0000,
		pos_diff_limit});
	// Current window limit expressed in raw current units.
	wire [23:0] cur_lim_w = cur_hyst_pct * FULL_SCALE / 8'd100;
	wire [15:0] cur_lim = cur_lim_w[15:0];
	wire cur_in_window = cur_magnitude <= cur_lim;
	wire [15:0] psum_abs = phase_cur_sum[15] ? -phase_cur_sum :
		phase_cur_sum;
	wire phase_sum_err = mode_enable && (psum_abs > cur_lim);
	wire duty_in_window = duty_ticks <= ctrl_hyst_ticks;
	wire undetectable = duty_in_window || torque_off_active;
	wire signed [15:0] cur_spd_eff = cur_in_window ? 16'sh0000 : cur_speed;
	wire signed [15:0] raw_speed;
	wire signed [31:0] div_den = $signed({16'h0000, scan_time_ms}) *
		$signed({28'h0000000, pole_pairs});
	wire signed [31:0] quot = (div_den == 32'sh0) ? 32'sh0 :
		pos_delta / div_den;
	assign raw_speed = quot[15:0];
	wire signed [15:0] filt_speed;
	wire [15:0] dev_raw = filt_speed - cur_spd_eff;
	wire [15:0] dev_abs = dev_raw[15] ? -dev_raw : dev_raw;
	wire speed_dev = mode_enable && !undetectable &&
		(dev_abs > speed_tol);
	wire pos_expired;
	wire dev_expired;
	wire pt1_bypass = pt1_time_us < {4'h0, PT1_MIN_US};
	wire [3:0] pt1_shift = pt1_time_us >= 20'd64000 ? 4'd6 :
		pt1_time_us >= 20'd16000 ? 4'd4 : 4'd2;
	pt1_filter u_pt1 (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.sample(scan_done & mode_enable),
		.bypass(pt1_bypass),
		.shift(pt1_shift),
		.din(raw_speed),
		.clear(~mode_enable),
		.dout(filt_speed)
	);
	persist_timer u_pos_timer (
		.clk(clk),
		.rstn(rstn),
		.ce(ce & eval_tick),
		.cond(pos_exceeded),
		.limit_ms(pos_diff_time_ms),
		.expired(pos_expired)
	);
	persist_timer u_dev_timer (
		.clk(clk),
		.rstn(rstn),
		.ce(ce & eval_tick),
		.cond(speed_dev),
		.limit_ms(speed_tol_time_ms),
		.expired(dev_expired)
	);
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_s <= 2'b00;
			sto_s <= 2'b00;
			brk_s <= 2'b00;
			ack_d <= 1'b0;
		end else if (ce) begin
			ack_s <= {ack_s[0], ack_pin};
			sto_s <= {sto_s[0], torque_off_req_pin};
			brk_s <= {brk_s[0], brake_req_pin};
			ack_d <= ack_s[1];
		end
	end
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_a <= 32'sh0;
			acc_b <= 32'sh0;
			acc_a_old <= 32'sh0;
			scan_cnt <= 16'h0000;
		end else if (ce) begin
			if (!mode_enable) begin
				acc_a <= 32'sh0;
				acc_b <= 32'sh0;
				acc_a_old <= 32'sh0;
				scan_cnt <= 16'h0000;
			end else if (eval_tick) begin
				acc_a <= acc_a + {{16{pos_step_a[15]}}, pos_step_a};
				acc_b <= acc_b + {{16{pos_step_b[15]}}, pos_step_b};
				if (scan_done) begin
					scan_cnt <= 16'h0000;
					acc_a_old <= acc_a;
				end else begin
					scan_cnt <= scan_cnt + 16'h0001;
				end
			end
		end
	end
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			speed <= 16'sh0000;
			speed_valid <= 1'b0;
		end else if (ce) begin
			if (!mode_enable) begin
				speed <= 16'sh0000;
				speed_valid <= 1'b0;
			end else if (ack_rise) begin
				speed <= 16'sh0000;
				speed_valid <= 1'b1;
			end else if (undetectable) begin
				speed_valid <= 1'b1;
				if (!keep_speed)
					speed <= 16'sh0000;
				// Keep on: speed register simply holds.
			end else if (!pos_exceeded) begin
				speed <= filt_speed;
				speed_valid <= 1'b1;
			end
		end
	end
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_d <= 1'b0;
			bus_window <= 1'b0;
			config_error <= 1'b0;
			safe_state <= 1'b0;
			torque_off_active <= 1'b0;
		end else if (ce) begin
			bus_d <= bus_started;
			bus_window <= bus_started & ~bus_d;
			torque_off_active <= sto_s[1];
			if (!mode_enable && speed_input_assigned)
				config_error <= 1'b1;
			// The clear comes first so that a fault in the same cycle wins.
			if (ack_rise && !pos_exceeded && !speed_dev)
				safe_state <= 1'b0;
			if (!mode_enable && bus_window && speed_ctrl_bits_set)
				safe_state <= 1'b1;
			if (pos_expired || dev_expired || phase_sum_err)
				safe_state <= 1'b1;
		end
	end
	// Torque-off masks every other function's active flag.
	wire [13:0] func_eff = torque_off_active ? 14'h0000 :
		(mode_enable ? func_active : (func_active & 14'h00e0));
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			safety_status_word <= `STATUS_RESET;
		end else if (ce && eval_tick) begin
			safety_status_word <= {15'h0000,
				func_eff[13:6],
				limit_breach | safe_state,
				func_eff[4:0],
				~brk_s[1],
				~torque_off_active,
				config_error | safe_state};
		end
	end
endmodule

// ### esm_defs.vh
// Constants for the encoderless speed monitor.
`ifndef ESM_DEFS_VH
`define ESM_DEFS_VH
`define CLK_PERIOD_NS 100
`define PT1_MIN_US 1000
`define PT1_MAX_US 256000
`define POS_DIFF_DEFAULT 16'h0168
`define CUR_HYST_DEFAULT 8'h02
`define CTRL_HYST_DEFAULT 16'h000a
`define TICK_NS 14
`define CYC_PER_MS 16'd10000
`define CUR_FULL_SCALE 16'd10000
`define ST_ERROR 0
`define ST_TORQUE_OFF_N 1
`define ST_BRAKE_OPEN 2
`define ST_STOP_ONE 3
`define ST_FAIL_SAFE 8
`define ST_ACCEL 9
`define ST_MAX_SPEED 16
`define STATUS_RESET 32'h00000000
`endif

// ### persist_timer.v
// Counts how long a fault condition has persisted and flags overrun.
`timescale 1ns/10ps
`include "esm_defs.vh"
module persist_timer (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire cond,
	input wire [15:0] limit_ms,
	output reg expired
);
	localparam [15:0] CYC_PER_MS = `CYC_PER_MS;
	reg [15:0] sub;
	reg [15:0] ms;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sub <= 16'h0000;
			ms <= 16'h0000;
			expired <= 1'b0;
		end else if (ce) begin
			if (!cond) begin
				sub <= 16'h0000;
				ms <= 16'h0000;
				expired <= 1'b0;
			end else begin
				if (ms >= limit_ms && sub != 16'h0000)
					expired <= 1'b1;
				if (sub == CYC_PER_MS - 16'h0001) begin
					sub <= 16'h0000;
					if (ms != 16'hffff)
						ms <= ms + 16'h0001;
				end else begin
					sub <= sub + 16'h0001;
				end
			end
		end
	end
endmodule

// ### pt1_filter.v
// First-order low-pass smoothing of the speed, with bypass.
`timescale 1ns/10ps
module pt1_filter (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire sample,
	input wire bypass,
	input wire [3:0] shift,
	input wire signed [15:0] din,
	input wire clear,
	output reg signed [15:0] dout
);
	reg signed [31:0] acc;
	wire signed [31:0] din_ext = {din, 16'h0000};
	wire signed [31:0] delta = (din_ext - acc) >>> shift;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc <= 32'h00000000;
			dout <= 16'h0000;
		end else if (ce) begin
			if (clear) begin
				acc <= 32'h00000000;
				dout <= 16'h0000;
			end else if (sample) begin
				if (bypass) begin
					acc <= din_ext;
					dout <= din;
				end else begin
					acc <= acc + delta;
					dout <= acc[31:16];
				end
			end
		end
	end
endmodule

// ### esm_asserts.sv
// Concurrent checks on the speed monitor ports.
`timescale 1ns/10ps
module esm_checker (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire mode_enable,
	input wire speed_input_assigned,
	input wire eval_tick,
	input wire torque_off_req_pin,
	input wire limit_breach,
	input wire [13:0] func_active,
	input wire speed_valid,
	input wire config_error,
	input wire torque_off_active,
	input wire [31:0] safety_status_word
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire [31:0] w = safety_status_word;
	a_mode_off_idle: assert property ((ce && !mode_enable)[*3] |-> !speed_valid)
		else $error("speed valid with mode off");
	a_cfg_sticky: assert property (config_error |=> config_error)
		else $error("config error dropped");
	a_cfg_cause: assert property ((ce && !mode_enable && speed_input_assigned)[*3]
		|-> config_error) else $error("config error missing");
	a_err_bit: assert property (ce && eval_tick && config_error |=> w[0])
		else $error("error bit low");
	a_func_bits: assert property (ce && eval_tick && mode_enable
		&& !torque_off_active |=>
		w[7:3] == $past(func_active[4:0]) &&
		w[16:9] == $past(func_active[13:6])) else $error("function bits wrong");
	a_upper_zero: assert property (w[31:17] == 15'h0000)
		else $error("upper status bits set");
	a_breach_bit: assert property (ce && eval_tick && limit_breach |=> w[8])
		else $error("breach bit low");
	a_torque_off: assert property ((ce && torque_off_req_pin)[*5]
		|-> torque_off_active) else $error("torque off not active");
	a_torque_mask: assert property (ce && eval_tick && torque_off_active |=>
		w[16:9] == 8'h00 && w[7:3] == 5'h00 && !w[1])
		else $error("torque off does not mask functions");
endmodule
bind encoderless_speed_monitor esm_checker i_esm_checker (.*);

// ### drive_model.sv
// Drive controller model feeding position, current and duty samples.
`timescale 1ns/10ps
module drive_model (
	input wire clk,
	input wire run,
	input wire skew,
	output reg signed [15:0] pos_step_a,
	output reg signed [15:0] pos_step_b,
	output reg signed [15:0] cur_speed,
	output reg [15:0] cur_magnitude,
	output reg signed [15:0] phase_cur_sum,
	output reg [15:0] duty_ticks
);
	// A stopped modulation gives no steps, no current and zero duty.
	always @(negedge clk) begin
		pos_step_a <= run ? 16'sh0008 : 16'sh0000;
		// A skewed second channel drifts eight counts per step.
		pos_step_b <= run ? (skew ? 16'sh0010 : 16'sh0008) : 16'sh0000;
		cur_speed <= run ? 16'sh0100 : 16'sh0000;
		cur_magnitude <= run ? 16'h1000 : 16'h0000;
		phase_cur_sum <= 16'sh0000;
		duty_ticks <= run ? 16'h0100 : 16'h0000;
	end
endmodule

// ### encoderless_speed_monitor_tb.sv
// Testbench for the encoderless speed monitor.
`timescale 1ns/10ps
module encoderless_speed_monitor_tb;
	reg clk = 0, rstn = 0, ce = 1, mode_enable = 1, keep_speed = 0, run = 0;
	reg speed_input_assigned = 0, bus_started = 0, speed_ctrl_bits_set = 0;
	reg eval_tick = 0, ack_pin = 0, torque_off_req_pin = 0;
	reg brake_req_pin = 0, limit_breach = 0;
	reg skew = 0;
	reg [3:0] pole_pairs = 4'h2;
	reg [15:0] scan_time_ms = 16'h0001, pos_diff_limit = 16'h0168;
	reg [15:0] pos_diff_time_ms = 16'h00c8, speed_tol = 16'hffff;
	reg [15:0] speed_tol_time_ms = 16'h00c8, ctrl_hyst_ticks = 16'h000a;
	reg [19:0] pt1_time_us = 20'h00000;
	reg [7:0] cur_hyst_pct = 8'h02;
	reg [13:0] func_active = 14'h0000;
	wire signed [15:0] pos_step_a, pos_step_b, cur_speed, phase_cur_sum, speed;
	wire [15:0] cur_magnitude, duty_ticks;
	wire speed_valid, config_error, safe_state, torque_off_active;
	wire [31:0] safety_status_word;
	reg signed [15:0] held;
	integer num_errors = 0, check_count = 0, i;
	initial forever #50 clk = ~clk;
	drive_model i_drive_model (.*);
	encoderless_speed_monitor i_encoderless_speed_monitor (.*);
	task chk(input [31:0] e, input [31:0] g);
		begin
		check_count = check_count + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
		end
	endtask
	task ticks(input integer n);
		integer k;
		for (k = 0; k < n; k = k + 1) begin
			@(negedge clk) eval_tick = 1;
			@(negedge clk) eval_tick = 0;
		end
	endtask
	function [31:0] st(input e);
		st = {15'h0000, func_active[13:6], limit_breach, func_active[4:0],
			~brake_req_pin, ~torque_off_req_pin, e};
	endfunction
	task t_bits;
		for (i = 0; i < 14; i = i + 1) begin
			func_active = 14'h0001 << i;
			ticks(2);
			chk(st(1'b0), safety_status_word);
		end
	endtask
	task t_pins;
		begin
		func_active = 14'h0000;
		torque_off_req_pin = 1;
		ticks(3);
		chk(st(1'b0), safety_status_word);
		chk(1, torque_off_active);
		torque_off_req_pin = 0;
		brake_req_pin = 1;
		ticks(3);
		chk(st(1'b0), safety_status_word);
		brake_req_pin = 0;
		limit_breach = 1;
		ticks(2);
		chk(st(1'b0), safety_status_word);
		limit_breach = 0;
		end
	endtask
	task t_speed;
		begin
		run = 1;
		keep_speed = 1;
		ticks(20);
		chk(1, speed_valid);
		// Eight counts per scan of one tick over two pole pairs.
		chk(32'h00000004, speed);
		held = speed;
		run = 0;
		ticks(5);
		chk(held, speed);
		ack_pin = 1;
		ticks(2);
		ack_pin = 0;
		ticks(2);
		chk(0, speed);
		keep_speed = 0;
		run = 1;
		ticks(20);
		chk(32'h00000004, speed);
		run = 0;
		ticks(5);
		chk(0, speed);
		end
	endtask
	task t_pos;
		begin
		pos_diff_time_ms = 16'h0000;
		skew = 1;
		run = 1;
		ticks(40);
		chk(0, safe_state);
		ticks(14);
		chk(1, safe_state);
		chk(1, safety_status_word[8]);
		run = 0;
		skew = 0;
		end
	endtask
	task t_bus;
		begin
		ack_pin = 1;
		ticks(2);
		ack_pin = 0;
		ticks(2);
		chk(0, safe_state);
		bus_started = 1;
		ticks(2);
		chk(0, safe_state);
		bus_started = 0;
		speed_ctrl_bits_set = 1;
		ticks(1);
		bus_started = 1;
		ticks(2);
		chk(1, safe_state);
		end
	endtask
	task t_mode;
		begin
		mode_enable = 0;
		speed_input_assigned = 1;
		ticks(3);
		chk(1, config_error);
		chk(0, speed_valid);
		chk(1, safety_status_word[0]);
		end
	endtask
	task report_and_stop;
		begin
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
		end
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rstn = 1;
		ticks(2);
		chk(32'h00000006, safety_status_word);
		t_bits;
		t_pins;
		t_speed;
		t_pos;
		t_mode;
		t_bus;
		report_and_stop;
	end
endmodule
